// >>> rtl/srce_engine.sv
/*
  Serial ROM command engine: register slave, three-wire ROM sequencer,
  station address reload and interrupt status.
  Assumes a 100 MHz core clock and a ROM data pin with a pull resistor.
*/
// Operation
// - A command runs only while the busy bit is set; no overlap.
// - Setting busy starts the command chosen by the three-bit code.
// - Write-all programs the data byte into every location.
// - Erase clears only the addressed location.
// - Erase-all starts a bulk erase of the whole ROM.
// - Reload fetches the station address; missing signature fails it.
// - No ROM answer within the timeout abandons and goes idle.
// - A timeout sets the timeout status bit.
// - Data line pulled high and no ROM: no timeout.
// - Without timeout, busy clears once the sequence is driven.
// - Line low and no ROM: only programming commands time out.
// - Loaded flag sets after reset or reload load; write one clears.
// - Loaded flag means valid ROM and completed address load.
// - The eight-bit address field addresses the ROM; resets to zero.
// - Data register low byte holds read or write byte; upper zero.
`timescale 1ns/1ps
`include "srce_params.svh"

module srce_engine
  import srce_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = `SRCE_TIMEOUT_CYC
) (
  input  wire logic        core_clk_in,
  input  wire logic        rst_n_in,
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic [31:0] reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic      [31:0] reg_rdata_out,
  output logic             irq_out,
  output logic             rom_sel_out,
  output logic             rom_clk_out,
  input  wire logic        rom_serial_data_pin_in,
  output logic             rom_serial_data_pin_out,
  output logic             rom_serial_data_pin_oe_n_out,
  output logic      [47:0] station_addr_out
);

  localparam logic [21:0] TOUT_LAST = 22'(TIMEOUT_CYCLES - 1);
  localparam logic [7:0]  SK_LAST   = 8'(`SRCE_SK_HALF_CYC - 1);

  logic [1:0]  rst_q;
  logic        rst_n;
  logic        din_m;
  logic        din_s;
  logic [7:0]  div_cnt;
  logic        tick;
  srce_bus_t   bus;
  srce_state_t state;
  srce_pins_t  pin;
  srce_op_t    cmd_op;
  srce_op_t    cur_op;
  logic        cmd_busy;
  logic        boot;
  logic [7:0]  cmd_addr;
  logic [7:0]  cur_addr;
  logic [7:0]  data;
  logic [18:0] sr;
  logic [4:0]  bitcnt;
  logic [7:0]  rx;
  logic [21:0] wd;
  logic        fin;
  logic        tout_ev;
  logic        load_ev;
  logic        rd_ev;
  logic        tout_flag;
  logic        loaded_flag;
  logic [2:0]  stat;
  logic [2:0]  mask;
  logic        go;
  logic        prog;
  logic        rdtype;

  // ************************************************************
  // Reset, pin synchroniser and serial clock divider
  // ************************************************************
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_q <= 2'h0;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_n = rst_q[1];

  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      din_m <= 1'b0;
      din_s <= 1'b0;
    end else begin
      din_m <= rom_serial_data_pin_in;
      din_s <= din_m;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= 8'h00;
    end else begin
      div_cnt <= tick ? 8'h00 : div_cnt + 8'h01;
    end
  end
  assign tick = (div_cnt == SK_LAST);

  assign bus    = {reg_addr_in, reg_wdata_in, reg_wr_in, reg_rd_in};
  assign go     = (state == S_IDLE) && cmd_busy && !fin;
  assign prog   = cur_op inside {SRCE_OP_WRITE, SRCE_OP_WRALL, SRCE_OP_ERASE, SRCE_OP_ERALL};
  assign rdtype = cur_op inside {SRCE_OP_READ, SRCE_OP_RELOAD};

  // Builds start bit, serial opcode, address and data, sent from the top bit.
  function automatic logic [18:0] frame_of(srce_op_t op, logic [7:0] a, logic [7:0] d);
    logic [1:0] opc;
    logic [7:0] fa;
    opc = `SRCE_SOP_READ;
    fa  = a;
    case (op)
      SRCE_OP_WRITE: opc = `SRCE_SOP_WRITE;
      SRCE_OP_ERASE: opc = `SRCE_SOP_ERASE;
      SRCE_OP_LOCK: begin
        opc = `SRCE_SOP_EXT;
        fa  = {`SRCE_EXT_LOCK, 6'h00};
      end
      SRCE_OP_UNLOCK: begin
        opc = `SRCE_SOP_EXT;
        fa  = {`SRCE_EXT_UNLOCK, 6'h00};
      end
      SRCE_OP_WRALL: begin
        opc = `SRCE_SOP_EXT;
        fa  = {`SRCE_EXT_WRALL, 6'h00};
      end
      SRCE_OP_ERALL: begin
        opc = `SRCE_SOP_EXT;
        fa  = {`SRCE_EXT_ERALL, 6'h00};
      end
      default: opc = `SRCE_SOP_READ;
    endcase
    return {1'b1, opc, fa, d};
  endfunction

  // ************************************************************
  // Command sequencer
  // ************************************************************
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      state    <= S_IDLE;
      pin      <= `SRCE_PINS_RST;
      cur_op   <= SRCE_OP_READ;
      cur_addr <= 8'h00;
      sr       <= 19'h00000;
      bitcnt   <= 5'h00;
      rx       <= 8'h00;
      wd       <= 22'h000000;
      fin      <= 1'b0;
      tout_ev  <= 1'b0;
      load_ev  <= 1'b0;
      rd_ev    <= 1'b0;
      station_addr_out <= 48'h000000000000;
    end else begin
      fin     <= 1'b0;
      tout_ev <= 1'b0;
      load_ev <= 1'b0;
      rd_ev   <= 1'b0;
      case (state)
        S_IDLE: if (go) begin
          cur_op   <= cmd_op;
          cur_addr <= (cmd_op == SRCE_OP_RELOAD) ? 8'h00 : cmd_addr;
          state    <= S_LOAD;
        end
        S_LOAD: begin
          pin.sel  <= 1'b1;
          pin.clk  <= 1'b0;
          pin.oe_n <= 1'b0;
          pin.dout <= 1'b1;
          sr       <= frame_of(cur_op, cur_addr, data);
          bitcnt   <= (cur_op inside {SRCE_OP_WRITE, SRCE_OP_WRALL}) ?
                      `SRCE_LEN_LONG : `SRCE_LEN_SHORT;
          state    <= S_SEND;
        end
        S_SEND: if (tick) begin
          pin.clk <= !pin.clk;
          if (pin.clk) begin
            sr       <= {sr[17:0], 1'b0};
            pin.dout <= sr[17];
            bitcnt   <= bitcnt - 5'h01;
            if (bitcnt == 5'h01) begin
              pin.dout <= 1'b0;
              if (rdtype) begin
                pin.oe_n <= 1'b1;
                bitcnt   <= `SRCE_LEN_READ;
                state    <= S_RECV;
              end else begin
                pin.sel <= 1'b0;
                state   <= S_GAP;
              end
            end
          end
        end
        S_RECV: if (tick) begin
          pin.clk <= !pin.clk;
          if (pin.clk) begin
            rx     <= {rx[6:0], din_s};
            bitcnt <= bitcnt - 5'h01;
            if (bitcnt == 5'h01) begin
              pin.sel <= 1'b0;
              state   <= S_GAP;
            end
          end
        end
        S_GAP: if (tick) begin
          pin.oe_n <= 1'b1;
          if (prog) begin
            pin.sel <= 1'b1;
            wd      <= 22'h000000;
            state   <= S_POLL;
          end else if (cur_op == SRCE_OP_RELOAD) begin
            if (cur_addr == 8'h00 && rx != `SRCE_SIGNATURE) begin
              fin   <= 1'b1;
              state <= S_IDLE;
            end else begin
              if (cur_addr != 8'h00) begin
                station_addr_out <= {rx, station_addr_out[47:8]};
              end
              if (cur_addr == `SRCE_LAST_BYTE) begin
                load_ev <= 1'b1;
                fin     <= 1'b1;
                state   <= S_IDLE;
              end else begin
                cur_addr <= cur_addr + 8'h01;
                state    <= S_LOAD;
              end
            end
          end else begin
            rd_ev <= (cur_op == SRCE_OP_READ);
            fin   <= 1'b1;
            state <= S_IDLE;
          end
        end
        S_POLL: if (din_s) begin
          pin.sel <= 1'b0;
          fin     <= 1'b1;
          state   <= S_IDLE;
        end else if (wd == TOUT_LAST) begin
          pin.sel <= 1'b0;
          tout_ev <= 1'b1;
          fin     <= 1'b1;
          state   <= S_IDLE;
        end else begin
          wd <= wd + 22'h000001;
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  assign rom_sel_out                  = pin.sel;
  assign rom_clk_out                  = pin.clk;
  assign rom_serial_data_pin_out      = pin.dout;
  assign rom_serial_data_pin_oe_n_out = pin.oe_n;

  // ************************************************************
  // Command and data registers
  // ************************************************************
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      boot     <= 1'b1;
      cmd_busy <= 1'b0;
      cmd_op   <= SRCE_OP_READ;
      cmd_addr <= 8'h00;
    end else begin
      boot <= 1'b0;
      if (boot) begin
        cmd_busy <= 1'b1;
        cmd_op   <= SRCE_OP_RELOAD;
      end else if (fin) begin
        cmd_busy <= 1'b0;
      end else if (bus.wr && bus.addr == `SRCE_CMD_OFS && !cmd_busy) begin
        cmd_busy <= bus.wdata[`SRCE_BUSY_BIT];
        cmd_op   <= srce_op_t'(bus.wdata[`SRCE_OP_MSB:`SRCE_OP_LSB]);
        cmd_addr <= bus.wdata[7:0];
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      data <= 8'h00;
    end else if (rd_ev) begin
      data <= rx;
    end else if (bus.wr && bus.addr == `SRCE_DATA_OFS && !cmd_busy) begin
      data <= bus.wdata[7:0];
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      tout_flag   <= 1'b0;
      loaded_flag <= 1'b0;
    end else begin
      if (tout_ev) begin
        tout_flag <= 1'b1;
      end else if (go) begin
        tout_flag <= 1'b0;
      end
      if (load_ev) begin
        loaded_flag <= 1'b1;
      end else if (bus.wr && bus.addr == `SRCE_CMD_OFS && bus.wdata[`SRCE_LOADED_BIT]) begin
        loaded_flag <= 1'b0;
      end
    end
  end

  // ************************************************************
  // Interrupt status, mask and read port
  // ************************************************************
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      stat    <= 3'h0;
      mask    <= 3'h0;
      irq_out <= 1'b0;
    end else begin
      stat    <= {load_ev, tout_ev, fin} |
                 ((bus.rd && bus.addr == `SRCE_STAT_OFS) ? 3'h0 : stat);
      irq_out <= |(stat & mask);
      if (bus.wr && bus.addr == `SRCE_MASK_OFS) begin
        mask <= bus.wdata[2:0];
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_out <= 32'h00000000;
    end else if (bus.rd) begin
      case (bus.addr)
        `SRCE_CMD_OFS:  reg_rdata_out <= {cmd_busy, cmd_op, 18'h00000,
                                          tout_flag, loaded_flag, cmd_addr};
        `SRCE_DATA_OFS: reg_rdata_out <= {24'h000000, data};
        `SRCE_STAT_OFS: reg_rdata_out <= {29'h00000000, stat};
        `SRCE_MASK_OFS: reg_rdata_out <= {29'h00000000, mask};
        default:        reg_rdata_out <= 32'h00000000;
      endcase
    end else begin
      reg_rdata_out <= 32'h00000000;
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n);

  sequence s_tout_hit;
    state == S_POLL && !din_s && wd == TOUT_LAST;
  endsequence
  sequence s_ready_seen;
    state == S_POLL && din_s;
  endsequence
  sequence s_back_idle;
    state == S_IDLE && fin ##1 !cmd_busy;
  endsequence

  property p_idle_hold;
    (state == S_IDLE && !cmd_busy) |=> state == S_IDLE;
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("engine left idle without busy");

  property p_go;
    (state == S_IDLE && cmd_busy && !fin) |=> state == S_LOAD ##1 pin.sel;
  endproperty
  a_go: assert property (p_go) else $error("busy command did not start");

  property p_tout;
    s_tout_hit |=> s_back_idle ##0 tout_flag;
  endproperty
  a_tout: assert property (p_tout) else $error("timeout not reported");

  property p_ready;
    s_ready_seen |=> s_back_idle ##0 !tout_flag;
  endproperty
  a_ready: assert property (p_ready) else $error("ready poll mishandled");

  property p_poll_prog;
    state == S_POLL |-> prog;
  endproperty
  a_poll_prog: assert property (p_poll_prog) else $error("non-programming command polled");

  property p_sig_fail;
    (state == S_GAP && tick && cur_op == SRCE_OP_RELOAD && cur_addr == 8'h00
     && rx != `SRCE_SIGNATURE) |=> !load_ev && state == S_IDLE ##1 !cmd_busy;
  endproperty
  a_sig_fail: assert property (p_sig_fail) else $error("bad signature not rejected");

  property p_loaded;
    load_ev |=> loaded_flag && $past(cur_addr) == `SRCE_LAST_BYTE;
  endproperty
  a_loaded: assert property (p_loaded) else $error("loaded flag not set");

  property p_read;
    rd_ev |=> data == $past(rx) && !cmd_busy;
  endproperty
  a_read: assert property (p_read) else $error("read byte not stored");

  property p_addr;
    (state == S_LOAD && cur_op != SRCE_OP_RELOAD) |-> cur_addr == cmd_addr;
  endproperty
  a_addr: assert property (p_addr) else $error("wrong ROM address");

endmodule

// >>> rtl/srce_params.svh
/*
  Offsets, field positions, codes and timing counts of the serial ROM
  command engine. Assumes a 100 MHz core clock.
*/
`ifndef SRCE_PARAMS_SVH
`define SRCE_PARAMS_SVH

`define SRCE_CMD_OFS      8'hB0
`define SRCE_DATA_OFS     8'hB4
`define SRCE_STAT_OFS     8'hB8
`define SRCE_MASK_OFS     8'hBC

`define SRCE_BUSY_BIT     31
`define SRCE_OP_MSB       30
`define SRCE_OP_LSB       28
`define SRCE_TOUT_BIT     9
`define SRCE_LOADED_BIT   8

`define SRCE_SIGNATURE    8'hA5
`define SRCE_LAST_BYTE    8'h06
`define SRCE_PINS_RST     4'h1

`define SRCE_SOP_READ     2'h2
`define SRCE_SOP_WRITE    2'h1
`define SRCE_SOP_ERASE    2'h3
`define SRCE_SOP_EXT      2'h0
`define SRCE_EXT_LOCK     2'h0
`define SRCE_EXT_UNLOCK   2'h3
`define SRCE_EXT_WRALL    2'h1
`define SRCE_EXT_ERALL    2'h2

`define SRCE_LEN_SHORT    5'h0B
`define SRCE_LEN_LONG     5'h13
`define SRCE_LEN_READ     5'h08

`define SRCE_CLK_NS       10
`define SRCE_SK_HALF_NS   500
`define SRCE_SK_HALF_CYC  (`SRCE_SK_HALF_NS / `SRCE_CLK_NS)
`define SRCE_TIMEOUT_MS   30
`define SRCE_TIMEOUT_CYC  (`SRCE_TIMEOUT_MS * 1000000 / `SRCE_CLK_NS)

`endif

// >>> rtl/srce_pkg.sv
/*
  Types of the serial ROM command engine.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package srce_pkg;

  typedef enum logic [2:0] {
    SRCE_OP_READ   = 3'h0,
    SRCE_OP_LOCK   = 3'h1,
    SRCE_OP_UNLOCK = 3'h2,
    SRCE_OP_WRITE  = 3'h3,
    SRCE_OP_WRALL  = 3'h4,
    SRCE_OP_ERASE  = 3'h5,
    SRCE_OP_ERALL  = 3'h6,
    SRCE_OP_RELOAD = 3'h7
  } srce_op_t;

  typedef enum logic [2:0] {S_IDLE, S_LOAD, S_SEND, S_RECV, S_GAP, S_POLL} srce_state_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } srce_bus_t;

  typedef struct packed {
    logic sel;
    logic clk;
    logic dout;
    logic oe_n;
  } srce_pins_t;

endpackage

// >>> test/srce_rom_model.sv
/*
  Behavioural three-wire serial ROM that faces the command engine.
  Assumes the engine splits the data pin into out, enable and in.
*/
`timescale 1ns/1ps

module srce_rom_model (
  input  wire logic        sel_in,
  input  wire logic        sclk_in,
  input  wire logic        host_dout_in,
  input  wire logic        host_oe_n_in,
  input  wire logic        present_in,
  input  wire logic        pull_hi_in,
  input  wire logic [15:0] busy_ns_in,
  output logic             line_out
);
  logic [7:0]  mem [256];
  logic [18:0] sh       = '0;
  logic [4:0]  nbit     = '0;
  logic        rdm      = 1'b0;
  logic        poll     = 1'b0;
  logic        busy     = 1'b0;
  logic        unlocked = 1'b0;
  logic        dval     = 1'b0;
  logic        pr;

  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'(i) ^ 8'h3C;
    end
    mem[0] = 8'hA5;
  end

  // A released and unselected line falls to the pull level.
  assign line_out = !host_oe_n_in ? host_dout_in :
                    !(present_in && sel_in) ? pull_hi_in :
                    poll ? !busy : rdm ? dval : pull_hi_in;

  // ****************************************
  // Frame capture and read data.
  // ****************************************
  always @(posedge sclk_in) begin
    if (sel_in && present_in) begin
      if (rdm) begin
        nbit = nbit + 5'h01;
        if (nbit > 5'h0B && nbit < 5'h14) dval = mem[sh[7:0]][5'h13 - nbit];
      end else if (nbit != 5'h00 || line_out) begin
        sh = {sh[17:0], line_out};
        nbit = nbit + 5'h01;
        rdm = (nbit == 5'h0B && sh[9:8] == 2'b10);
      end
    end
  end

  // ****************************************
  // Frame end: lock state and programming.
  // ****************************************
  always @(negedge sel_in) begin
    poll = 1'b0;
    if (present_in && !rdm) begin
      if (nbit == 5'h0B && sh[9:6] == 4'b0000) unlocked = 1'b0;
      if (nbit == 5'h0B && sh[9:6] == 4'b0011) unlocked = 1'b1;
      pr = unlocked && (nbit == 5'h0B ? (sh[9:8] == 2'b11 || sh[9:6] == 4'b0010) :
                        (sh[17:16] == 2'b01 || sh[17:14] == 4'b0001));
      if (pr && nbit == 5'h0B && sh[9:8] == 2'b11) mem[sh[7:0]] = 8'hFF;
      if (pr && nbit == 5'h13 && sh[17:16] == 2'b01) mem[sh[15:8]] = sh[7:0];
      for (int i = 0; i < 256; i++) begin
        if (pr && nbit == 5'h0B && sh[9:6] == 4'b0010) mem[i] = 8'hFF;
        if (pr && nbit == 5'h13 && sh[17:14] == 4'b0001) mem[i] = sh[7:0];
      end
      poll = pr;
    end
    nbit = '0;
    rdm = 1'b0;
    sh = '0;
    if (poll) begin
      busy = 1'b1;
      #(busy_ns_in);
      busy = 1'b0;
    end
  end
endmodule

// >>> test/tb_top.sv
/*
  Self-checking bench for the serial ROM command engine.
  Assumes the ROM model beside it and a short timeout count.
*/
`timescale 1ns/1ps
`include "srce_params.svh"

module tb_top
  import srce_pkg::*;
;
  localparam int TOUT = 200;
  logic        core_clk = 1'b0;
  logic        rst_n    = 1'b0;
  srce_bus_t   bus      = '0;
  srce_pins_t  pins;
  logic [31:0] rdata;
  logic [47:0] station;
  logic        irq;
  logic        line;
  logic        present  = 1'b1;
  logic        pull_hi  = 1'b1;
  logic [15:0] busy_ns  = 16'h04B0;
  int          fails    = 0;
  int          n_tests  = 0;
  int          cyc      = 0;

  srce_engine #(.TIMEOUT_CYCLES(TOUT)) dut_u (
    .core_clk_in                  (core_clk),
    .rst_n_in                     (rst_n),
    .reg_addr_in                  (bus.addr),
    .reg_wdata_in                 (bus.wdata),
    .reg_wr_in                    (bus.wr),
    .reg_rd_in                    (bus.rd),
    .reg_rdata_out                (rdata),
    .irq_out                      (irq),
    .rom_sel_out                  (pins.sel),
    .rom_clk_out                  (pins.clk),
    .rom_serial_data_pin_in       (line),
    .rom_serial_data_pin_out      (pins.dout),
    .rom_serial_data_pin_oe_n_out (pins.oe_n),
    .station_addr_out             (station)
  );

  srce_rom_model rom_u (
    .sel_in       (pins.sel),
    .sclk_in      (pins.clk),
    .host_dout_in (pins.dout),
    .host_oe_n_in (pins.oe_n),
    .present_in   (present),
    .pull_hi_in   (pull_hi),
    .busy_ns_in   (busy_ns),
    .line_out     (line)
  );

  // ****************************************
  // Register access and checking tasks.
  // ****************************************
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [47:0] got, input logic [47:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge core_clk);
    bus.wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    bus <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge core_clk);
    bus.rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string what);
    logic [31:0] d;
    rd(a, d);
    chk(48'(d), 48'(e), what);
  endtask

  task automatic wait_idle();
    logic [31:0] d;
    d = 32'h8000_0000;
    for (int n = 0; n < 10000 && d[31] !== 1'b0; n++) rd(`SRCE_CMD_OFS, d);
    chk(48'(d[31]), 48'h0, "busy");
  endtask

  task automatic run(input logic [2:0] op, input logic [7:0] a);
    wr(`SRCE_CMD_OFS, {1'b1, op, 20'h0, a});
    wait_idle();
  endtask

  always #5 core_clk = ~core_clk;

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 99000) begin
      fails++;
      test_done();
    end
  end

  // ****************************************
  // Main sequence.
  // ****************************************
  initial begin
    logic to;
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    rchk(`SRCE_CMD_OFS, 32'hF000_0000, "boot busy");
    rchk(`SRCE_DATA_OFS, 32'h0, "data rst");
    wr(`SRCE_CMD_OFS, 32'h8000_0033);
    wait_idle();
    rchk(`SRCE_CMD_OFS, 32'h7000_0100, "boot cmd");
    chk(station, 48'h3A39_383F_3E3D, "station");
    rchk(`SRCE_STAT_OFS, 32'h5, "stat");
    wr(8'h40, 32'hFFFF_FFFF);
    rchk(8'h40, 32'h0, "unmapped");
    wr(`SRCE_CMD_OFS, 32'h0000_0100);
    rchk(`SRCE_CMD_OFS, 32'h0, "loaded clr");
    wr(`SRCE_DATA_OFS, 32'hFFFF_FFC3);
    rchk(`SRCE_DATA_OFS, 32'hC3, "data ro");
    run(SRCE_OP_WRITE, 8'h10);
    run(SRCE_OP_READ, 8'h10);
    rchk(`SRCE_DATA_OFS, 32'h2C, "locked");
    run(SRCE_OP_UNLOCK, 8'h00);
    wr(`SRCE_DATA_OFS, 32'hC3);
    wr(`SRCE_CMD_OFS, 32'hB000_0010);
    wr(`SRCE_DATA_OFS, 32'h99);
    wr(`SRCE_CMD_OFS, 32'hE000_0000);
    wait_idle();
    rchk(`SRCE_DATA_OFS, 32'hC3, "busy refuse");
    run(SRCE_OP_READ, 8'h10);
    rchk(`SRCE_DATA_OFS, 32'hC3, "write");
    busy_ns <= 16'h0000;
    run(SRCE_OP_ERASE, 8'h10);
    run(SRCE_OP_READ, 8'h10);
    rchk(`SRCE_DATA_OFS, 32'hFF, "erase");
    run(SRCE_OP_READ, 8'h11);
    rchk(`SRCE_DATA_OFS, 32'h2D, "erase one");
    busy_ns <= 16'h04B0;
    wr(`SRCE_DATA_OFS, 32'h5A);
    run(SRCE_OP_WRALL, 8'h00);
    run(SRCE_OP_READ, 8'hFF);
    rchk(`SRCE_DATA_OFS, 32'h5A, "wrall");
    run(SRCE_OP_RELOAD, 8'h00);
    rchk(`SRCE_CMD_OFS, 32'h7000_0000, "no sig");
    chk(station, 48'h3A39_383F_3E3D, "sig kept");
    run(SRCE_OP_ERALL, 8'h00);
    run(SRCE_OP_READ, 8'h80);
    rchk(`SRCE_DATA_OFS, 32'hFF, "erall");
    wr(`SRCE_DATA_OFS, 32'hA5);
    run(SRCE_OP_WRITE, 8'h00);
    wr(`SRCE_DATA_OFS, 32'h11);
    run(SRCE_OP_WRITE, 8'h01);
    run(SRCE_OP_RELOAD, 8'h00);
    rchk(`SRCE_CMD_OFS, 32'h7000_0100, "reload");
    chk(station, 48'hFFFF_FFFF_FF11, "station");
    run(SRCE_OP_LOCK, 8'h00);
    wr(`SRCE_DATA_OFS, 32'h77);
    run(SRCE_OP_WRITE, 8'h20);
    run(SRCE_OP_READ, 8'h20);
    rchk(`SRCE_DATA_OFS, 32'hFF, "relocked");
    // No ROM fitted, line pulled low; only the timeout event may interrupt.
    present <= 1'b0;
    pull_hi <= 1'b0;
    wr(`SRCE_MASK_OFS, 32'h2);
    rchk(`SRCE_MASK_OFS, 32'h2, "mask");
    rchk(`SRCE_STAT_OFS, 32'h5, "stat");
    for (int i = 0; i < 7; i++) begin
      to = (i >= 3);
      run(3'(i), 8'h05);
      chk(48'(irq), 48'(to), "irq");
      rchk(`SRCE_CMD_OFS, {1'b0, 3'(i), 18'h0, to, 1'b1, 8'h05}, "cmd");
      rchk(`SRCE_STAT_OFS, {30'h0, to, 1'b1}, "stat");
      @(posedge core_clk);
      #1 chk(48'(irq), 48'h0, "irq clr");
    end
    pull_hi <= 1'b1;
    for (int i = 3; i < 7; i += 2) begin
      run(3'(i), 8'h05);
      rchk(`SRCE_CMD_OFS, {1'b0, 3'(i), 20'h1, 8'h05}, "no tout");
    end
    test_done();
  end
endmodule
